// ===== nt_dchannel_priority_handler.sv
// Chosen here: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module nt_dchannel_priority_handler
    import nt_dch_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Highway pins
    input  wire logic        hw_clk_i,
    input  wire logic        hw_fsc_i,
    input  wire logic        upstream_line_i,
    output logic             upstream_line_o,
    output logic             upstream_line_oe_o,
    output logic             downstream_line_o,
    output logic             downstream_line_oe_o,
    // S-bus layer-1 side
    input  wire logic        s_d_i,
    input  wire logic        s_d_valid_i,
    input  wire logic        permit_i,
    output logic             echo_o
);

    function automatic logic [3:0] need_ones(input logic prio, input logic abort);
        if (prio) begin
            need_ones = abort ? N_PRIO10_ABORT : N_PRIO10_FLAG;
        end else begin
            need_ones = abort ? N_PRIO8_ABORT : N_PRIO8_FLAG;
        end
    endfunction

    function automatic logic [3:0] count_one(input logic [3:0] cnt, input logic bit_v);
        if (!bit_v) begin
            count_one = 4'h0;
        end else if (cnt == ONES_MAX) begin
            count_one = cnt;
        end else begin
            count_one = cnt + 4'h1;
        end
    endfunction

    arb_regs_s r;
    arb_regs_s next_r;

    logic       clk_rise;
    logic       clk_fall;
    logic       fsc_rise;
    logic [7:0] cur_pos;
    logic       active;
    logic       hw_bit;
    logic       sg_state;
    logic       sg_out;
    logic       wb_req;

    always_comb begin
        next_r   = r;
        clk_rise = r.clk_sy[1] & ~r.clk_q;
        clk_fall = ~r.clk_sy[1] & r.clk_q;
        fsc_rise = r.fsc_sy[1] & ~r.fsc_q;
        cur_pos  = fsc_rise ? 8'h00 : r.bitpos;
        hw_bit   = r.up_sy[1];
        active   = r.enable & r.slt_mode;
        wb_req   = wb_cyc_i & wb_stb_i & ~r.wb_ack;
        // Stop/go 1 in S access and ready
        sg_state = active && (r.state == ST_READY || r.state == ST_S_ACCESS);
        sg_out   = sg_state | (active & ~permit_i);

        // Pin synchronisers
        next_r.clk_sy = {r.clk_sy[0], hw_clk_i};
        next_r.fsc_sy = {r.fsc_sy[0], hw_fsc_i};
        next_r.up_sy  = {r.up_sy[0], upstream_line_i};
        next_r.clk_q  = r.clk_sy[1];
        next_r.fsc_q  = r.fsc_sy[1];

        // Register bus
        next_r.wb_ack = wb_req;
        if (wb_req && wb_we_i && wb_adr_i == CTRL_OFFSET && wb_sel_i[0]) begin
            next_r.enable   = wb_dat_i[CTRL_ENABLE_BIT];
            next_r.prio     = wb_dat_i[CTRL_PRIO_BIT];
            next_r.slt_mode = wb_dat_i[CTRL_SLT_BIT];
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFFSET: begin
                    next_r.wb_dat = {29'h0, r.slt_mode, r.prio, r.enable};
                end
                STATUS_OFFSET: begin
                    next_r.wb_dat = {16'h0, r.need, r.hw_ones, r.last_abort, r.frame_abort,
                                     sg_state, permit_i, r.s_ones[1:0], r.state};
                end
                default: begin
                    next_r.wb_dat = 32'h0;
                end
            endcase
        end

        // S-bus D bits and echo
        if (s_d_valid_i) begin
            next_r.s_d    = s_d_i;
            next_r.s_ones = count_one(r.s_ones, s_d_i);
            if (active && (r.state == ST_LOCAL || !permit_i)) begin
                next_r.echo = ~s_d_i;
            end else begin
                next_r.echo = s_d_i;
            end
        end

        // Frame sync restarts the bit count
        if (fsc_rise) begin
            next_r.bitpos = 8'h00;
        end
        // Highway sampling on link clock rise
        if (clk_rise) begin
            next_r.bitpos = cur_pos + 8'h01;
            if (cur_pos == POS_D0 || cur_pos == POS_D1) begin
                next_r.hw_ones = count_one(r.hw_ones, hw_bit);
                if (r.state == ST_LOCAL) begin
                    if (hw_bit && r.hw_ones == FLAG_ONES) begin
                        next_r.frame_abort = 1'b1;
                    end else if (!hw_bit && r.hw_ones == FLAG_ONES) begin
                        next_r.frame_abort = 1'b0;
                    end
                end
            end
        end

        // Arbitration state machine
        if (!active) begin
            next_r.state = ST_IDLE;
        end else begin
            case (r.state)
                ST_IDLE, ST_READY: begin
                    if (clk_rise && cur_pos == POS_BUS_ACC && !hw_bit) begin
                        next_r.state       = ST_LOCAL;
                        next_r.frame_abort = 1'b0;
                    end else if (r.state == ST_IDLE && s_d_valid_i && !s_d_i) begin
                        next_r.state = ST_S_ACCESS;
                    end else if (r.state == ST_READY && r.hw_ones >= r.need) begin
                        next_r.state = ST_IDLE;
                    end
                end
                ST_S_ACCESS: begin
                    // Eight S-bus ones end S access
                    if (r.s_ones >= IDLE_ONES) begin
                        next_r.state = ST_IDLE;
                    end
                end
                ST_LOCAL: begin
                    if (clk_rise && cur_pos == POS_BUS_ACC && hw_bit) begin
                        next_r.state      = ST_READY;
                        next_r.last_abort = r.frame_abort;
                        next_r.need       = need_ones(r.prio, r.frame_abort);
                        next_r.hw_ones    = 4'h0;
                    end
                end
                default: begin
                    next_r.state = ST_IDLE;
                end
            endcase
        end
        if (next_r.state == ST_S_ACCESS && r.state != ST_S_ACCESS) begin
            next_r.s_ones = 4'h0;
        end

        // Highway drive on link clock fall
        if (clk_fall) begin
            next_r.up_oe  = 1'b0;
            next_r.dn_oe  = 1'b0;
            if (active && r.state != ST_LOCAL && (r.bitpos == POS_D0 || r.bitpos == POS_D1)) begin
                next_r.up_oe  = 1'b1;
                next_r.up_out = r.s_d;
            end
            if (active && r.bitpos == POS_SG) begin
                next_r.dn_oe  = 1'b1;
                next_r.dn_out = sg_out;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r          <= '0;
            r.state    <= ST_IDLE;
            r.echo     <= 1'b1;
            r.s_d      <= 1'b1;
            r.up_out   <= 1'b1;
            r.need     <= N_PRIO8_FLAG;
            r.enable   <= CTRL_RESET[CTRL_ENABLE_BIT];
            r.prio     <= CTRL_RESET[CTRL_PRIO_BIT];
            r.slt_mode <= CTRL_RESET[CTRL_SLT_BIT];
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_o             = r.wb_dat;
    assign wb_ack_o             = r.wb_ack;
    assign upstream_line_o      = r.up_out;
    assign upstream_line_oe_o   = r.up_oe;
    assign downstream_line_o    = r.dn_out;
    assign downstream_line_oe_o = r.dn_oe;
    assign echo_o               = r.echo;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    a_local_echo_inv: assert property (
        (r.state == ST_LOCAL && active && s_d_valid_i) |=> echo_o == !$past(s_d_i))
        else $error("echo not inverted in local access");
    a_permit_block: assert property (
        (active && !permit_i && s_d_valid_i) |=> echo_o == !$past(s_d_i))
        else $error("echo not inverted while permit is 0");
    a_echo_follow: assert property (
        (r.state != ST_LOCAL && permit_i && s_d_valid_i) |=> echo_o == $past(s_d_i))
        else $error("echo does not follow received D");
    a_ready_after_local: assert property (
        (r.state == ST_LOCAL && next_r.state != ST_LOCAL && active) |=> r.state == ST_READY)
        else $error("local end did not go to ready");
    a_ready_sg: assert property (
        ($rose(downstream_line_oe_o) && $past(r.state) == ST_READY && $past(active)) |-> downstream_line_o)
        else $error("stop/go not 1 in ready");
    a_idle_sg: assert property (
        ($rose(downstream_line_oe_o) && $past(r.state) == ST_IDLE && $past(permit_i)) |-> !downstream_line_o)
        else $error("stop/go not 0 in idle");
    a_need_prio: assert property (
        (r.state == ST_LOCAL && next_r.state == ST_READY)
        |=> r.need == ($past(r.prio) ? (r.last_abort ? N_PRIO10_ABORT : N_PRIO10_FLAG)
                                     : (r.last_abort ? N_PRIO8_ABORT : N_PRIO8_FLAG)))
        else $error("idle count wrong for priority");
    a_ready_exit: assert property (
        (r.state == ST_READY && active && r.hw_ones < r.need && !(clk_rise && cur_pos == POS_BUS_ACC))
        |=> r.state == ST_READY)
        else $error("ready left before n ones");
    a_s_access_sg: assert property (
        (r.state == ST_S_ACCESS && active) |-> sg_out)
        else $error("stop/go not 1 in S access");
    a_s_exit_idle: assert property (
        (r.state == ST_S_ACCESS && active && r.s_ones >= IDLE_ONES) |=> r.state == ST_IDLE)
        else $error("S access not left after eight ones");
    a_disabled_idle: assert property (!active |=> r.state == ST_IDLE)
        else $error("handler active while disabled");
    a_sg_slot_only: assert property (
        downstream_line_oe_o |-> (r.bitpos == POS_SG || r.bitpos == POS_SG + 8'h01))
        else $error("downstream driven outside stop/go slot");
    a_up_slot_only: assert property (
        upstream_line_oe_o |-> (r.bitpos == POS_D0 || r.bitpos == POS_D1 || r.bitpos == POS_D1 + 8'h01))
        else $error("upstream driven outside D slots");

endmodule
`default_nettype wire

// ===== nt_dch_pkg.sv
`default_nettype none
package nt_dch_pkg;
    // Register map (byte addresses)
    localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
    // Control register field positions
    localparam int          CTRL_ENABLE_BIT  = 0;
    localparam int          CTRL_PRIO_BIT    = 1;
    localparam int          CTRL_SLT_BIT     = 2;
    localparam logic [2:0]  CTRL_RESET       = 3'h0;
    // Highway frame bit positions
    localparam logic [7:0]  POS_D0           = 8'h18;
    localparam logic [7:0]  POS_D1           = 8'h19;
    localparam logic [7:0]  POS_BUS_ACC      = 8'h5A;
    localparam logic [7:0]  POS_SG           = 8'h5B;
    // Idle-bit counts
    localparam logic [3:0]  N_PRIO8_FLAG     = 4'h9;
    localparam logic [3:0]  N_PRIO8_ABORT    = 4'h8;
    localparam logic [3:0]  N_PRIO10_FLAG    = 4'hB;
    localparam logic [3:0]  N_PRIO10_ABORT   = 4'hA;
    localparam logic [3:0]  IDLE_ONES        = 4'h8;
    localparam logic [3:0]  FLAG_ONES        = 4'h6;
    localparam logic [3:0]  ABORT_ONES       = 4'h7;
    localparam logic [3:0]  ONES_MAX         = 4'hF;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READY,
        ST_S_ACCESS,
        ST_LOCAL
    } arb_state_e;

    typedef struct packed {
        logic [1:0] clk_sy;
        logic [1:0] fsc_sy;
        logic [1:0] up_sy;
        logic       clk_q;
        logic       fsc_q;
        logic [7:0] bitpos;
        arb_state_e state;
        logic [3:0] hw_ones;
        logic [3:0] s_ones;
        logic [3:0] need;
        logic       frame_abort;
        logic       last_abort;
        logic       s_d;
        logic       echo;
        logic       up_out;
        logic       up_oe;
        logic       dn_out;
        logic       dn_oe;
        logic       wb_ack;
        logic [31:0] wb_dat;
        logic       enable;
        logic       prio;
        logic       slt_mode;
    } arb_regs_s;
endpackage
`default_nettype wire

// ===== nt_dch_pkg_end.sv
`default_nettype none
`default_nettype wire

// ===== nt_hw_partner.sv
`default_nettype none
module nt_hw_partner (
    // Link pins
    output logic            hw_clk_o,
    output logic            hw_fsc_o,
    output logic            line_o,
    output logic            line_oe_o,
    input  wire logic       up_wire_i,
    input  wire logic       dn_wire_i,
    // Bench control and view
    input  wire logic       send_i,
    input  wire logic [1:0] d_i,
    output logic            sg_o,
    output logic            d_seen_o,
    output logic [15:0]     frames_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hold;
    logic free;
    initial begin
        {hw_clk_o, hw_fsc_o, line_o, line_oe_o, sg_o, d_seen_o, hold, free} = '0;
        frames_o = '0;
        forever begin
            for (int k = 0; k < 96; k++) begin
                #62.5 hw_clk_o = 1'b0;
                hw_fsc_o = (k == 0);
                line_o = 1'b0;
                line_oe_o = 1'b0;
                // Claim free line, release when done
                if (k == 8'h5A) begin
                    hold = send_i && (hold || free);
                    line_oe_o = hold;
                end
                if ((k == 8'h18 || k == 8'h19) && hold && !sg_o) begin
                    line_oe_o = 1'b1;
                    line_o = (k == 8'h18) ? d_i[0] : d_i[1];
                end
                #62.5 hw_clk_o = 1'b1;
                if (k == 8'h18) d_seen_o = up_wire_i;
                if (k == 8'h5A) free = up_wire_i;
                if (k == 8'h5B) sg_o = dn_wire_i;
            end
            frames_o = frames_o + 16'h1;
        end
    end
endmodule
`default_nettype wire

// ===== nt_dchannel_priority_handler_tb.sv
`default_nettype none
module nt_dchannel_priority_handler_tb
    import nt_dch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        hw_clk, hw_fsc, up_o, up_oe, dn_o, dn_oe, s_d_i, s_d_valid_i, permit_i, echo_o;
    logic        p_line, p_oe, send, sg, d_seen, up_wire, dn_wire;
    logic [1:0]  d;
    logic [15:0] frames;
    int          fails, num_checks;
    assign up_wire = (~up_oe | up_o) & (~p_oe | p_line);
    assign dn_wire = ~dn_oe | dn_o;
    always #2 clk_i = ~clk_i;
    nt_dchannel_priority_handler u_nt_dchannel_priority_handler (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .hw_clk_i(hw_clk), .hw_fsc_i(hw_fsc), .upstream_line_i(up_wire), .upstream_line_o(up_o),
        .upstream_line_oe_o(up_oe), .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe),
        .s_d_i(s_d_i), .s_d_valid_i(s_d_valid_i), .permit_i(permit_i), .echo_o(echo_o));
    nt_hw_partner u_nt_hw_partner (.hw_clk_o(hw_clk), .hw_fsc_o(hw_fsc), .line_o(p_line),
        .line_oe_o(p_oe), .up_wire_i(up_wire), .dn_wire_i(dn_wire), .send_i(send), .d_i(d),
        .sg_o(sg), .d_seen_o(d_seen), .frames_o(frames));
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) fails++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic st(input logic [1:0] exp);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        check("state", {30'h0, q[1:0]}, {30'h0, exp});
    endtask
    task automatic sd(input logic b);
        @(posedge clk_i);
        s_d_i <= b;
        s_d_valid_i <= 1'b1;
        @(posedge clk_i);
        s_d_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic fw(input int n);
        repeat (n) @(frames);
        @(posedge clk_i);
    endtask
    task automatic t_regs;
        wb(1'b0, CTRL_OFFSET, 32'h0);
        check("ctrl reset", q, 32'h0);
        wb(1'b1, CTRL_OFFSET, 32'h5);
        wb(1'b0, CTRL_OFFSET, 32'h0);
        check("ctrl", q & 32'h7, 32'h5);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", q, 32'h0);
        st(2'h0);
    endtask
    task automatic t_idle;
        fw(2);
        check("sg idle", sg, 1'b0);
        check("d idle", d_seen, 1'b1);
        sd(1'b1);
        check("echo idle", echo_o, 1'b1);
    endtask
    task automatic t_sbus;
        sd(1'b0);
        check("echo s", echo_o, 1'b0);
        st(2'h2);
        fw(1);
        check("sg s", sg, 1'b1);
        check("d s", d_seen, 1'b0);
        repeat (7) sd(1'b1);
        st(2'h2);
        sd(1'b1);
        st(2'h0);
        fw(1);
        check("sg s end", sg, 1'b0);
    endtask
    task automatic t_permit;
        permit_i <= 1'b0;
        sd(1'b1);
        check("echo block", echo_o, 1'b0);
        fw(1);
        check("sg block", sg, 1'b1);
        permit_i <= 1'b1;
        fw(1);
        check("sg permit", sg, 1'b0);
    endtask
    // Last pattern 01 closes with a flag, 11 runs into seven ones, an abort
    task automatic t_local(input logic prio, input logic [1:0] last_pat, input logic [3:0] n);
        logic [1:0] pat [4];
        pat = '{2'b10, 2'b11, 2'b11, last_pat};
        wb(1'b1, CTRL_OFFSET, {29'h0, 1'b1, prio, 1'b1});
        send <= 1'b1;
        d <= 2'b11;
        fw(1);
        st(2'h3);
        sd(1'b1);
        check("echo local", echo_o, 1'b0);
        for (int i = 0; i < 4; i++) begin
            d <= pat[i];
            fw(1);
        end
        d <= 2'b11;
        send <= 1'b0;
        fw(1);
        st(2'h1);
        check("n", {28'h0, q[15:12]}, {28'h0, n});
        check("sg ready", sg, 1'b1);
        sd(1'b1);
        check("echo ready", echo_o, 1'b1);
        fw(n / 2 + 2);
        st(2'h0);
        check("sg back", sg, 1'b0);
    endtask
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, s_d_i, s_d_valid_i, send} = '0;
        {wb_adr_i, wb_dat_i, fails, num_checks} = '0;
        wb_sel_i = 4'hF;
        rst_i = 1'b1;
        permit_i = 1'b1;
        d = 2'b11;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_idle;
        t_sbus;
        t_permit;
        t_local(1'b0, 2'b01, N_PRIO8_FLAG);
        t_local(1'b1, 2'b11, N_PRIO10_ABORT);
        summarize;
    end
    initial begin
        #420000;
        fails++;
        summarize;
    end
endmodule
`default_nettype wire
